// *** hdl/rcp_pkg.sv ***
// Constants for the reset-cause and digital PLL configuration registers
package rcp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] RSC_OFFSET = 8'h74;
  localparam logic [7:0] PLL_OFFSET = 8'h84;
  // Reset-cause register field positions
  localparam int LP_FLAG_BIT = 31;
  localparam int WWDG_FLAG_BIT = 30;
  localparam int FWDG_FLAG_BIT = 29;
  localparam int SW_FLAG_BIT = 28;
  localparam int POR_FLAG_BIT = 27;
  localparam int PIN_FLAG_BIT = 26;
  localparam int FLAG_LSB = 26;
  localparam int FLAG_W = 6;
  localparam int CLEAR_BIT = 24;
  localparam int OSC_STABLE_BIT = 1;
  localparam int OSC_ENABLE_BIT = 0;
  // Digital PLL configuration field positions
  localparam int DIV_LSB = 26;
  localparam int DIV_W = 6;
  localparam int FSEL_LSB = 24;
  localparam int FSEL_W = 2;
  // Reset values
  localparam logic [31:0] RSC_RESET = 32'h0C000000;
  localparam logic [31:0] PLL_RESET = 32'h0B000000;
  localparam logic [5:0] FLAGS_RESET = 6'h03;
  localparam logic [5:0] DIV_RESET = 6'h02;
  localparam logic [1:0] FSEL_RESET = 2'h3;
endpackage : rcp_pkg

// *** hdl/rcp_regs.sv ***
// Reset-cause flags, slow RC oscillator control and digital PLL configuration registers
//
// Functional notes
// - Deep-sleep or standby reset sets the low-power flag, bit 31.
// - Window watchdog reset sets its flag, bit 30.
// - Free watchdog reset sets its flag, bit 29.
// - Software reset request sets its flag, bit 28.
// - Power-on reset sets the power flag, bit 27.
// - External pin reset sets the pin flag, bit 26.
// - Writing 1 to bit 24 clears all six flags; 0 does nothing.
// - Only power reset returns the flags to their reset value.
// - Clear bit and oscillator enable reset on every system reset.
// - Bit 0 enables the 32 kHz oscillator; bit 1 reads its stability.
// - Divider field 31:26 divides the PLL output by value plus one.
// - Field 25:24 picks PLL output: 192, 240, 320 or 480 MHz.
// - Byte, half-word and word accesses touch only addressed bytes.
module rcp_regs (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic POWER_RESET_N_I,
  input wire logic REG_SEL_I,
  input wire logic REG_WRITE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [3:0] REG_BYTE_EN_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic LOW_POWER_RESET_I,
  input wire logic WINDOW_WATCHDOG_RESET_I,
  input wire logic FREE_WATCHDOG_RESET_I,
  input wire logic SOFTWARE_RESET_I,
  input wire logic PIN_RESET_I,
  input wire logic OSC_STABLE_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_READY_O,
  output logic SLOW_RC_OSC_ENABLE_O,
  output logic [5:0] SYS_CLOCK_DIVIDER_O,
  output logic [1:0] PLL_OUTPUT_FREQ_SELECT_O
);

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the asynchronous event and status inputs
  logic [5:0] evt_meta;
  logic [5:0] evt_sync;
  logic [5:0] next_evt_meta;
  logic [5:0] next_evt_sync;

  always_comb
  begin
    next_evt_meta = {LOW_POWER_RESET_I, WINDOW_WATCHDOG_RESET_I, FREE_WATCHDOG_RESET_I,
                     SOFTWARE_RESET_I, PIN_RESET_I, OSC_STABLE_I};
    next_evt_sync = evt_meta;
  end

  // No reset here: the flags must still see the cause that is holding the system in reset
  // Only the second stage feeds the logic below; the first may still be settling
  always_ff @(posedge CLK_I)
  begin
    evt_meta <= next_evt_meta;
    evt_sync <= next_evt_sync;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read and write decode
  // Unmapped addresses still answer, so a stray access cannot stall the bus
  logic wr_rsc;
  logic wr_pll;
  logic rd_rsc;
  logic rd_pll;

  always_comb
  begin
    wr_rsc = 1'b0;
    wr_pll = 1'b0;
    rd_rsc = 1'b0;
    rd_pll = 1'b0;
    if (REG_SEL_I && REG_ADDR_I == rcp_pkg::RSC_OFFSET)
    begin
      wr_rsc = REG_WRITE_I;
      rd_rsc = !REG_WRITE_I;
    end
    else if (REG_SEL_I && REG_ADDR_I == rcp_pkg::PLL_OFFSET)
    begin
      wr_pll = REG_WRITE_I;
      rd_pll = !REG_WRITE_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset-cause flags, kept on the power reset only
  logic [5:0] flags;
  logic [5:0] next_flags;
  logic clear_req;
  logic [5:0] set_vec;

  always_comb
  begin
    // Clear applies to the pending write byte 3 bit 24 only; flag bits themselves are read-only
    clear_req = wr_rsc && REG_BYTE_EN_I[3] && REG_WDATA_I[rcp_pkg::CLEAR_BIT];
    set_vec = {evt_sync[5], evt_sync[4], evt_sync[3], evt_sync[2], 1'b0, evt_sync[1]};
    next_flags = flags;
    if (clear_req)
    begin
      next_flags = '0;
    end
    // A cause arriving with the clear wins over it
    next_flags = next_flags | set_vec;
  end

  // The system reset leaves these alone, so the cause behind a reset survives it
  always_ff @(posedge CLK_I)
  begin
    if (!POWER_RESET_N_I)
    begin
      // Power reset records itself, reset value of the flag field
      flags <= rcp_pkg::FLAGS_RESET;
    end
    else
    begin
      flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clear bit, oscillator enable and PLL configuration, on system reset
  logic clear_bit;
  logic osc_en;
  logic [5:0] div;
  logic [1:0] fsel;
  logic next_clear_bit;
  logic next_osc_en;
  logic [5:0] next_div;
  logic [1:0] next_fsel;

  always_comb
  begin
    next_clear_bit = clear_bit;
    next_osc_en = osc_en;
    next_div = div;
    next_fsel = fsel;
    // The clear bit reads back as written; flags are cleared by the write itself
    if (wr_rsc && REG_BYTE_EN_I[3])
    begin
      next_clear_bit = REG_WDATA_I[rcp_pkg::CLEAR_BIT];
    end
    if (wr_rsc && REG_BYTE_EN_I[0])
    begin
      next_osc_en = REG_WDATA_I[rcp_pkg::OSC_ENABLE_BIT];
    end
    // Divider and select only move on a write that enables the top byte lane
    if (wr_pll && REG_BYTE_EN_I[3])
    begin
      next_div = REG_WDATA_I[rcp_pkg::DIV_LSB +: rcp_pkg::DIV_W];
      next_fsel = REG_WDATA_I[rcp_pkg::FSEL_LSB +: rcp_pkg::FSEL_W];
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I || !POWER_RESET_N_I)
    begin
      clear_bit <= 1'b0;
      osc_en <= 1'b0;
      div <= rcp_pkg::DIV_RESET;
      fsel <= rcp_pkg::FSEL_RESET;
    end
    else
    begin
      clear_bit <= next_clear_bit;
      osc_en <= next_osc_en;
      div <= next_div;
      fsel <= next_fsel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data and outputs; unmapped addresses read zero
  logic [31:0] next_rdata;
  logic next_ready;

  always_comb
  begin
    next_rdata = '0;
    next_ready = REG_SEL_I;
    if (rd_rsc)
    begin
      next_rdata[rcp_pkg::FLAG_LSB +: rcp_pkg::FLAG_W] = flags;
      next_rdata[rcp_pkg::CLEAR_BIT] = clear_bit;
      // Masked by the enable: a status left over from before a disable must not read as stable
      next_rdata[rcp_pkg::OSC_STABLE_BIT] = evt_sync[0] & osc_en;
      next_rdata[rcp_pkg::OSC_ENABLE_BIT] = osc_en;
    end
    else if (rd_pll)
    begin
      next_rdata[rcp_pkg::DIV_LSB +: rcp_pkg::DIV_W] = div;
      next_rdata[rcp_pkg::FSEL_LSB +: rcp_pkg::FSEL_W] = fsel;
    end
  end

  // Outputs load the next values so they move on the same edge as the registers behind them;
  // the power reset loads their reset values as well, keeping them in step with those registers
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I || !POWER_RESET_N_I)
    begin
      REG_RDATA_O <= '0;
      REG_READY_O <= 1'b0;
      SLOW_RC_OSC_ENABLE_O <= 1'b0;
      SYS_CLOCK_DIVIDER_O <= rcp_pkg::DIV_RESET;
      PLL_OUTPUT_FREQ_SELECT_O <= rcp_pkg::FSEL_RESET;
    end
    else
    begin
      REG_RDATA_O <= next_rdata;
      REG_READY_O <= next_ready;
      SLOW_RC_OSC_ENABLE_O <= next_osc_en;
      SYS_CLOCK_DIVIDER_O <= next_div;
      PLL_OUTPUT_FREQ_SELECT_O <= next_fsel;
    end
  end

endmodule : rcp_regs

// *** dv/rcp_regs_assertions.sv ***
// Port-level checks on the register slice
module rcp_regs_checker (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic POWER_RESET_N_I,
  input wire logic REG_SEL_I,
  input wire logic REG_WRITE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [3:0] REG_BYTE_EN_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic REG_READY_O,
  input wire logic SLOW_RC_OSC_ENABLE_O,
  input wire logic [5:0] SYS_CLOCK_DIVIDER_O,
  input wire logic [1:0] PLL_OUTPUT_FREQ_SELECT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I || !POWER_RESET_N_I);
  wire logic rq = REG_SEL_I && !REG_WRITE_I;
  wire logic wr = REG_SEL_I && REG_WRITE_I;
  wire logic pll = REG_ADDR_I == 8'h84;
  wire logic rsc = REG_ADDR_I == 8'h74;
  wire logic [7:0] cfg = {SYS_CLOCK_DIVIDER_O, PLL_OUTPUT_FREQ_SELECT_O};
  property p_rdy; REG_SEL_I |=> REG_READY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_idle; !REG_SEL_I |=> !REG_READY_O; endproperty
  a_idle: assert property (p_idle) else $error("stray ready");
  property p_unm; rq && !pll && !rsc |=> REG_RDATA_O == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped data");
  property p_wr; wr |=> REG_RDATA_O == 32'h0; endproperty
  a_wr: assert property (p_wr) else $error("write data");
  property p_cfg; wr && pll && REG_BYTE_EN_I[3] |=> cfg == $past(REG_WDATA_I[31:24]); endproperty
  a_cfg: assert property (p_cfg) else $error("pll config");
  property p_lane; wr && pll && !REG_BYTE_EN_I[3] |=> $stable(cfg); endproperty
  a_lane: assert property (p_lane) else $error("lane leak");
  property p_osc; wr && rsc && REG_BYTE_EN_I[0] |=> SLOW_RC_OSC_ENABLE_O == $past(REG_WDATA_I[0]); endproperty
  a_osc: assert property (p_osc) else $error("osc enable");
  property p_resv; rq && pll |=> REG_RDATA_O[23:0] == 24'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits");
  property p_rsvr; rq && rsc |=> REG_RDATA_O[25] == 1'b0 && REG_RDATA_O[23:2] == 22'h0; endproperty
  a_rsvr: assert property (p_rsvr) else $error("reserved cause bits");
endmodule : rcp_regs_checker
bind rcp_regs rcp_regs_checker u_chk (.*);

// *** dv/rcp_regs_test.sv ***
// Self-checking bench for the register slice
module rcp_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_n = 1'h0, por_n = 1'h0, sel = 1'h0, we = 1'h0, stb = 1'h0, rdy;
  logic [7:0] adr = 8'h00;
  logic [3:0] be = 4'h0;
  logic [4:0] cause = 5'h00;
  logic [31:0] wd = 32'h0, rd;
  wire logic [8:0] outs;
  int n_fail = 0, n_compared = 0;
  always #25 clk = ~clk;
  rcp_regs DUT (.CLK_I(clk), .RESET_N_I(rst_n), .POWER_RESET_N_I(por_n), .REG_SEL_I(sel), .REG_WRITE_I(we),
    .REG_ADDR_I(adr), .REG_BYTE_EN_I(be), .REG_WDATA_I(wd), .LOW_POWER_RESET_I(cause[0]),
    .WINDOW_WATCHDOG_RESET_I(cause[1]), .FREE_WATCHDOG_RESET_I(cause[2]), .SOFTWARE_RESET_I(cause[3]),
    .PIN_RESET_I(cause[4]), .OSC_STABLE_I(stb), .REG_RDATA_O(rd), .REG_READY_O(rdy),
    .SLOW_RC_OSC_ENABLE_O(outs[8]), .SYS_CLOCK_DIVIDER_O(outs[7:2]), .PLL_OUTPUT_FREQ_SELECT_O(outs[1:0]));
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk
  task automatic test_done();
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // A read hands its expected word in d; a write always answers zero
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    tk(1);
    sel = 1'h1;
    we = w;
    adr = a;
    be = b;
    wd = d;
    tk(1);
    sel = 1'h0;
    cmp({31'h0, rdy}, 32'h1);
    cmp(rd, w ? 32'h0 : d);
  endtask : acc
  // Causes are pulsed one cycle; flags land three edges later
  task automatic pulse(input int i);
    cause[i] = 1'h1;
    tk(1);
    cause[i] = 1'h0;
    tk(4);
  endtask : pulse
  initial
  begin
    tk(10);
    rst_n = 1'h1;
    por_n = 1'h1;
    acc(1'h0, 8'h74, 4'h0, 32'h0C000000);
    acc(1'h0, 8'h84, 4'h0, 32'h0B000000);
    cmp(32'(outs), 32'h0000000B);
    acc(1'h1, 8'h74, 4'h8, 32'h01000000);
    for (int i = 0; i < 5; i++)
    begin
      pulse(i);
      acc(1'h1, 8'h74, 4'h8, 32'hFC000000);
      acc(1'h0, 8'h74, 4'h0, i < 4 ? 32'h80000000 >> i : 32'h04000000);
      acc(1'h1, 8'h74, 4'h8, 32'h01000000);
      acc(1'h0, 8'h74, 4'h0, 32'h01000000);
    end
    // A cause still present during the clear write wins over it
    cause[0] = 1'h1;
    tk(3);
    acc(1'h1, 8'h74, 4'h8, 32'h01000000);
    acc(1'h0, 8'h74, 4'h0, 32'h81000000);
    cause[0] = 1'h0;
    tk(3);
    acc(1'h1, 8'h74, 4'h8, 32'h01000000);
    acc(1'h1, 8'h74, 4'h1, 32'h00000003);
    acc(1'h0, 8'h74, 4'h0, 32'h01000001);
    cmp(32'(outs), 32'h0000010B);
    stb = 1'h1;
    tk(3);
    acc(1'h0, 8'h74, 4'h0, 32'h01000003);
    pulse(4);
    rst_n = 1'h0;
    tk(3);
    rst_n = 1'h1;
    acc(1'h0, 8'h74, 4'h0, 32'h04000000);
    cmp(32'(outs), 32'h0000000B);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'h1, 8'h84, 4'h8, {6'(63 - i), 2'(i), 24'h0});
      acc(1'h0, 8'h84, 4'h0, {6'(63 - i), 2'(i), 24'h0});
    end
    acc(1'h1, 8'h84, 4'h7, 32'h0);
    acc(1'h0, 8'h84, 4'h0, 32'hF3000000);
    cmp(32'(outs), 32'h000000F3);
    acc(1'h0, 8'h78, 4'h0, 32'h0);
    por_n = 1'h0;
    tk(2);
    por_n = 1'h1;
    acc(1'h0, 8'h74, 4'h0, 32'h0C000000);
    acc(1'h0, 8'h84, 4'h0, 32'h0B000000);
    cmp(32'(outs), 32'h0000000B);
    test_done();
  end
  // The whole sequence needs about 140 cycles
  initial
  begin
    tk(3000);
    n_fail++;
    test_done();
  end
endmodule : rcp_regs_test
